// file: logic/dwdc_consts.svh
// constants for the data word decoder and calibration block
`ifndef DWDC_CONSTS_SVH
`define DWDC_CONSTS_SVH
`define DWDC_CHANNELS 40
`define DWDC_DATA_W 14
`define DWDC_OFFSET_RESET 14'h2000
`define DWDC_GAIN_RESET 14'h3ffe
`define DWDC_CODE_RESET 14'h0000
`define DWDC_CLEAR_RESET 14'h0000
`define DWDC_CTRL_RESET 14'h2000
`define DWDC_CTRL_INT_REF_BIT 10
`define DWDC_CTRL_REF_MAG_BIT 12
`define DWDC_CTRL_MON_EN_BIT 9
`define DWDC_MON_ADDR_LSB 8
`define DWDC_MON_OFF_CHAN 6'h3f
`define DWDC_CMD_NOP 6'h00
`define DWDC_CMD_CLEAR_CODE 6'h01
`define DWDC_CMD_SOFT_CLEAR 6'h02
`define DWDC_CMD_POWER_DOWN 6'h08
`define DWDC_CMD_POWER_UP 6'h09
`define DWDC_CMD_MONITOR 6'h0a
`define DWDC_CMD_CONTROL 6'h0c
`define DWDC_CMD_SOFT_RESET 6'h0f
`endif

// file: logic/dwdc_pkg.sv
// types for the data word decoder and calibration block
package dwdc_pkg;
	typedef enum logic [1:0] {
		DWDC_SEL_SPECIAL = 2'h0,
		DWDC_SEL_GAIN = 2'h1,
		DWDC_SEL_OFFSET = 2'h2,
		DWDC_SEL_CODE = 2'h3
	} dwdc_select_t;
	typedef enum logic [2:0] {
		DWDC_ST_IDLE = 3'h1,
		DWDC_ST_SCAN = 3'h2,
		DWDC_ST_DONE = 3'h4
	} dwdc_state_t;
endpackage

// file: logic/dwdc_mem.sv
// per-channel word store with write port and registered read
`timescale 1ns/10ps
module dwdc_mem #(
	parameter int DEPTH = 40,
	parameter int WIDTH = 14,
	parameter logic [13:0] INIT = 14'h0000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// write port
	input wire logic wr_en,
	input wire logic [5:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic init_all,
	// read port
	input wire logic [5:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	initial begin
		if (DEPTH > 64 || WIDTH != 14) $error("dwdc_mem: unsupported shape");
	end
	// storage, reset or soft reset to init value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) mem[i] <= INIT;
		end else if (init_all) begin
			for (int i = 0; i < DEPTH; i++) mem[i] <= INIT;
		end else if (wr_en && int'(wr_addr) < DEPTH) begin
			mem[wr_addr] <= wr_data;
		end
	end
	// registered read, zero beyond depth
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= '0;
		end else begin
			rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
		end
	end
endmodule

// file: logic/dwdc_top.sv
// data word decoder with per-channel gain and offset correction
`timescale 1ns/10ps
`include "dwdc_consts.svh"
module dwdc_top #(
	parameter int CHANNELS = `DWDC_CHANNELS
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic SYS_RST,
	// host word, from the pins
	input wire logic WRITE_STROBE,
	input wire logic READ_NOT_WRITE,
	input wire logic REGISTER_SELECT_HIGH,
	input wire logic REGISTER_SELECT_LOW,
	input wire logic [5:0] CHANNEL_OR_COMMAND_ADDRESS,
	input wire logic [13:0] DATA_WORD_LINES,
	input wire logic LOAD_OUTPUTS_STROBE_N,
	// readback
	output logic [13:0] READ_DATA,
	output logic READ_VALID,
	// converter side
	output logic [13:0] CONVERTER_CODE,
	output logic [5:0] CONVERTER_CHANNEL,
	output logic CONVERTER_WRITE,
	output logic UPDATE_ALL,
	// control state
	output logic INTERNAL_REFERENCE_ENABLE,
	output logic REFERENCE_MAGNITUDE_SELECT,
	output logic POWERED_DOWN,
	output logic MONITOR_ENABLE,
	output logic [5:0] MONITOR_CHANNEL,
	output logic BUSY_N
);
	initial begin
		if (CHANNELS < 1 || CHANNELS > 63) $error("dwdc_top: channel count unsupported");
	end

	// two-stage synchronisers on every pin input; load strobe bit idles high
	logic [24:0] sync1;
	logic [24:0] sync2;
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sync1 <= 25'h1000000;
			sync2 <= 25'h1000000;
		end else begin
			sync1 <= {LOAD_OUTPUTS_STROBE_N, WRITE_STROBE, READ_NOT_WRITE,
				REGISTER_SELECT_HIGH, REGISTER_SELECT_LOW,
				CHANNEL_OR_COMMAND_ADDRESS, DATA_WORD_LINES};
			sync2 <= sync1;
		end
	end
	logic strobe_d;
	logic load_n_d;
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			strobe_d <= 1'b0;
			load_n_d <= 1'b1;
		end else begin
			strobe_d <= sync2[23];
			load_n_d <= sync2[24];
		end
	end

	// word fields and decode
	wire [13:0] word = sync2[13:0];
	wire [5:0] addr = sync2[19:14];
	wire [1:0] sel = sync2[21:20];
	wire rnw = sync2[22];
	wire take = sync2[23] & ~strobe_d;
	wire load_fire = ~sync2[24] & load_n_d; // falling edge of load strobe
	wire is_chan = sel != dwdc_pkg::DWDC_SEL_SPECIAL;
	wire chan_ok = int'(addr) < CHANNELS;
	logic powered_down;
	logic soft_reset;
	wire wr_ok = take & ~rnw & ~powered_down;
	wire wr_code = wr_ok & chan_ok & (sel == dwdc_pkg::DWDC_SEL_CODE);
	wire wr_off = wr_ok & chan_ok & (sel == dwdc_pkg::DWDC_SEL_OFFSET);
	wire wr_gain = wr_ok & chan_ok & (sel == dwdc_pkg::DWDC_SEL_GAIN);
	wire cmd = take & ~is_chan;
	wire cmd_wr = cmd & ~rnw;
	wire do_clear_code = cmd_wr & ~powered_down & (addr == `DWDC_CMD_CLEAR_CODE);
	wire do_soft_clear = cmd_wr & ~powered_down & (addr == `DWDC_CMD_SOFT_CLEAR);
	wire do_pdown = cmd_wr & (addr == `DWDC_CMD_POWER_DOWN);
	wire do_pup = cmd_wr & (addr == `DWDC_CMD_POWER_UP);
	wire do_ctrl_wr = cmd_wr & ~powered_down & (addr == `DWDC_CMD_CONTROL);
	wire do_ctrl_rd = cmd & rnw & (addr == `DWDC_CMD_CONTROL);
	wire do_monitor = cmd_wr & ~powered_down & (addr == `DWDC_CMD_MONITOR);
	wire do_reset = cmd_wr & ~powered_down & (addr == `DWDC_CMD_SOFT_RESET);
	wire chan_rd = take & rnw & is_chan;

	// gain word keeps its lowest bit at zero
	wire [13:0] gain_word = {word[13:1], 1'b0};

	// per-channel stores; a separate pair of trims per channel
	logic [5:0] rd_addr;
	logic [13:0] code_q;
	logic [13:0] off_q;
	logic [13:0] gain_q;
	logic [13:0] clear_code;
	dwdc_mem #(.DEPTH(CHANNELS), .WIDTH(14), .INIT(`DWDC_CODE_RESET)) u_code (
		.clk(CLOCK), .rst(SYS_RST), .wr_en(wr_code), .wr_addr(addr), .wr_data(word),
		.init_all(soft_reset), .rd_addr(rd_addr), .rd_data(code_q)
	);
	dwdc_mem #(.DEPTH(CHANNELS), .WIDTH(14), .INIT(`DWDC_OFFSET_RESET)) u_off (
		.clk(CLOCK), .rst(SYS_RST), .wr_en(wr_off), .wr_addr(addr), .wr_data(word),
		.init_all(soft_reset), .rd_addr(rd_addr), .rd_data(off_q)
	);
	dwdc_mem #(.DEPTH(CHANNELS), .WIDTH(14), .INIT(`DWDC_GAIN_RESET)) u_gain (
		.clk(CLOCK), .rst(SYS_RST), .wr_en(wr_gain), .wr_addr(addr), .wr_data(gain_word),
		.init_all(soft_reset), .rd_addr(rd_addr), .rd_data(gain_q)
	);

	// correction: x2 = (m+2)*x1/2^14 + c - 2^13, clamped
	function automatic logic [13:0] correct(input logic [13:0] x1, input logic [13:0] m,
			input logic [13:0] c);
		logic [28:0] prod;
		logic signed [16:0] sum;
		prod = ({15'h0000, x1}) * ({15'h0000, m} + 29'h00000002);
		sum = $signed({2'b00, prod[28:14]}) + $signed({3'b000, c}) - 17'sh02000;
		if (sum < 0) correct = 14'h0000;
		else if (sum > 17'sh03fff) correct = 14'h3fff;
		else correct = sum[13:0];
	endfunction

	// scan state machine: walks every channel after a load or clear
	dwdc_pkg::dwdc_state_t state;
	dwdc_pkg::dwdc_state_t next_state;
	logic [5:0] scan_idx;
	logic [5:0] out_idx;
	logic scan_pending;
	logic clear_mode;
	wire scan_end = int'(scan_idx) == CHANNELS - 1;
	always_comb begin
		case (state)
			dwdc_pkg::DWDC_ST_IDLE: next_state = scan_pending ? dwdc_pkg::DWDC_ST_SCAN
				: dwdc_pkg::DWDC_ST_IDLE;
			dwdc_pkg::DWDC_ST_SCAN: next_state = scan_end ? dwdc_pkg::DWDC_ST_DONE
				: dwdc_pkg::DWDC_ST_SCAN;
			dwdc_pkg::DWDC_ST_DONE: next_state = dwdc_pkg::DWDC_ST_IDLE;
			default: next_state = dwdc_pkg::DWDC_ST_IDLE;
		endcase
	end
	wire scanning = state == dwdc_pkg::DWDC_ST_SCAN;
	assign rd_addr = scanning ? scan_idx : addr;

	// state, scan index and pending scan request from load, soft clear or soft reset
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state <= dwdc_pkg::DWDC_ST_IDLE;
			scan_idx <= 6'h00;
			scan_pending <= 1'b0;
			clear_mode <= 1'b0;
		end else begin
			state <= next_state;
			scan_idx <= scanning ? scan_idx + 6'h01 : 6'h00;
			if (load_fire | do_soft_clear | soft_reset) begin
				scan_pending <= 1'b1;
				clear_mode <= do_soft_clear | soft_reset;
			end else if (state == dwdc_pkg::DWDC_ST_IDLE) begin
				scan_pending <= 1'b0;
			end
		end
	end

	// converter write stream, one channel per cycle from registered reads
	// write and update follow the two-stage read path so code and channel line up
	logic scan_d1;
	logic done_d1;
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			out_idx <= 6'h00;
			scan_d1 <= 1'b0;
			done_d1 <= 1'b0;
			CONVERTER_WRITE <= 1'b0;
			CONVERTER_CHANNEL <= 6'h00;
			CONVERTER_CODE <= 14'h0000;
			UPDATE_ALL <= 1'b0;
		end else begin
			out_idx <= scan_idx;
			scan_d1 <= scanning;
			done_d1 <= state == dwdc_pkg::DWDC_ST_DONE;
			CONVERTER_WRITE <= scan_d1;
			CONVERTER_CHANNEL <= out_idx;
			CONVERTER_CODE <= clear_mode ? clear_code : correct(code_q, gain_q, off_q);
			UPDATE_ALL <= done_d1;
		end
	end

	// control, clear code, power and monitor state
	logic [13:0] ctrl;
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ctrl <= `DWDC_CTRL_RESET;
			clear_code <= `DWDC_CLEAR_RESET;
			powered_down <= 1'b0;
			soft_reset <= 1'b0;
			MONITOR_CHANNEL <= `DWDC_MON_OFF_CHAN;
		end else begin
			soft_reset <= do_reset;
			if (do_reset) begin
				ctrl <= `DWDC_CTRL_RESET;
				clear_code <= `DWDC_CLEAR_RESET;
				MONITOR_CHANNEL <= `DWDC_MON_OFF_CHAN;
			end else begin
				if (do_ctrl_wr) ctrl <= word;
				if (do_clear_code) clear_code <= word;
				if (do_monitor) MONITOR_CHANNEL <= word[13:`DWDC_MON_ADDR_LSB];
			end
			if (do_pdown) powered_down <= 1'b1;
			else if (do_pup) powered_down <= 1'b0;
		end
	end

	// readback: channel registers one cycle after the registered read
	logic rd_pend;
	logic [1:0] rd_sel;
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rd_pend <= 1'b0;
			rd_sel <= 2'h0;
			READ_DATA <= 14'h0000;
			READ_VALID <= 1'b0;
		end else begin
			rd_pend <= chan_rd & ~scanning;
			rd_sel <= sel;
			READ_VALID <= rd_pend | do_ctrl_rd;
			if (do_ctrl_rd) READ_DATA <= ctrl;
			else if (rd_pend) begin
				case (rd_sel)
					dwdc_pkg::DWDC_SEL_CODE: READ_DATA <= code_q;
					dwdc_pkg::DWDC_SEL_OFFSET: READ_DATA <= off_q;
					default: READ_DATA <= gain_q;
				endcase
			end
		end
	end

	// control bits to the analog side; busy covers the whole output pipeline
	assign INTERNAL_REFERENCE_ENABLE = ctrl[`DWDC_CTRL_INT_REF_BIT];
	assign REFERENCE_MAGNITUDE_SELECT = ctrl[`DWDC_CTRL_REF_MAG_BIT] & ctrl[`DWDC_CTRL_INT_REF_BIT];
	assign MONITOR_ENABLE = ctrl[`DWDC_CTRL_MON_EN_BIT];
	assign POWERED_DOWN = powered_down;
	assign BUSY_N = (state == dwdc_pkg::DWDC_ST_IDLE) & ~scan_pending & ~scan_d1
		& ~CONVERTER_WRITE & ~done_d1 & ~UPDATE_ALL;
endmodule

// file: tb/dwdc_top_props.sv
// checker on the converter stream, readback and reference outputs
`timescale 1ns/10ps
module dwdc_top_props #(
	parameter int CHANNELS = 40
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic SYS_RST,
	// watched outputs
	input wire logic [13:0] READ_DATA,
	input wire logic READ_VALID,
	input wire logic [5:0] CONVERTER_CHANNEL,
	input wire logic CONVERTER_WRITE,
	input wire logic UPDATE_ALL,
	input wire logic INTERNAL_REFERENCE_ENABLE,
	input wire logic REFERENCE_MAGNITUDE_SELECT,
	input wire logic POWERED_DOWN,
	input wire logic BUSY_N
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	// stream ordering, the common update, reference select and readback
	a_write_in_scan: assert property (CONVERTER_WRITE |-> !BUSY_N)
		else $error("converter write outside a scan");
	a_chan_range: assert property (CONVERTER_WRITE |-> CONVERTER_CHANNEL < CHANNELS)
		else $error("converter channel out of range");
	a_first_chan: assert property ($rose(CONVERTER_WRITE) |-> CONVERTER_CHANNEL == 6'h00)
		else $error("scan does not start at channel zero");
	a_chan_step: assert property (CONVERTER_WRITE && CONVERTER_CHANNEL < CHANNELS - 1 |=>
		CONVERTER_WRITE && CONVERTER_CHANNEL == 6'($past(CONVERTER_CHANNEL) + 1))
		else $error("channel stream broken");
	a_update_last: assert property (CONVERTER_WRITE && CONVERTER_CHANNEL == CHANNELS - 1 |->
		##[1:3] UPDATE_ALL) else $error("no update after last channel");
	a_update_pulse: assert property (UPDATE_ALL |=> !UPDATE_ALL && !CONVERTER_WRITE)
		else $error("update pulse too long");
	a_scan_starts: assert property ($fell(BUSY_N) |-> ##[1:8] CONVERTER_WRITE)
		else $error("pending scan never starts");
	a_ref_mag: assert property (REFERENCE_MAGNITUDE_SELECT |-> INTERNAL_REFERENCE_ENABLE)
		else $error("magnitude set with external reference");
	a_read_pulse: assert property (READ_VALID |=> !READ_VALID)
		else $error("read valid longer than one cycle");
	a_read_hold: assert property ($changed(READ_DATA) |-> READ_VALID)
		else $error("read data changed without a read");
	// main scenarios
	c_update: cover property (UPDATE_ALL);
	c_read: cover property (READ_VALID);
	c_pdown: cover property ($rose(POWERED_DOWN));
endmodule
bind dwdc_top dwdc_top_props #(.CHANNELS(CHANNELS)) props_u (.CLOCK, .SYS_RST, .READ_DATA,
	.READ_VALID, .CONVERTER_CHANNEL, .CONVERTER_WRITE, .UPDATE_ALL, .INTERNAL_REFERENCE_ENABLE,
	.REFERENCE_MAGNITUDE_SELECT, .POWERED_DOWN, .BUSY_N);

// file: tb/dwdc_host.sv
// host model driving the word, strobe and load pins
`timescale 1ns/10ps
module dwdc_host (
	// clock
	input wire logic CLOCK,
	// pins toward the device
	output logic WRITE_STROBE,
	output logic READ_NOT_WRITE,
	output logic [1:0] SEL,
	output logic [5:0] CHANNEL_OR_COMMAND_ADDRESS,
	output logic [13:0] DATA_WORD_LINES,
	output logic LOAD_OUTPUTS_STROBE_N
);
	// idle levels at time zero
	initial begin
		WRITE_STROBE = 1'b0;
		READ_NOT_WRITE = 1'b0;
		SEL = 2'h0;
		CHANNEL_OR_COMMAND_ADDRESS = 6'h2a;
		DATA_WORD_LINES = 14'h1555;
		LOAD_OUTPUTS_STROBE_N = 1'b1;
	end
	// one word with select and address, held well around the strobe
	task automatic put(input logic rnw, input logic [1:0] sel, input logic [5:0] adr,
		input logic [13:0] dat);
		@(posedge CLOCK);
		READ_NOT_WRITE <= rnw;
		SEL <= sel;
		CHANNEL_OR_COMMAND_ADDRESS <= adr;
		DATA_WORD_LINES <= dat;
		repeat (4) @(posedge CLOCK);
		WRITE_STROBE <= 1'b1;
		repeat (4) @(posedge CLOCK);
		WRITE_STROBE <= 1'b0;
		repeat (4) @(posedge CLOCK);
		// released lines stop showing the last word
		CHANNEL_OR_COMMAND_ADDRESS <= ~adr;
		DATA_WORD_LINES <= ~dat;
		repeat (2) @(posedge CLOCK);
	endtask
	// load strobe low for four cycles
	task automatic load();
		@(posedge CLOCK);
		LOAD_OUTPUTS_STROBE_N <= 1'b0;
		repeat (4) @(posedge CLOCK);
		LOAD_OUTPUTS_STROBE_N <= 1'b1;
	endtask
endmodule

// file: tb/test_dac_word_decode_calibrate.sv
// bench: random trims and codes, commands, readback
`timescale 1ns/10ps
module test_dac_word_decode_calibrate;
	logic CLOCK = 1'b0;
	logic SYS_RST = 1'b1;
	logic WRITE_STROBE, READ_NOT_WRITE, LOAD_OUTPUTS_STROBE_N, READ_VALID, CONVERTER_WRITE;
	logic UPDATE_ALL, INTERNAL_REFERENCE_ENABLE, REFERENCE_MAGNITUDE_SELECT, POWERED_DOWN;
	logic MONITOR_ENABLE, BUSY_N;
	logic [1:0] sel;
	logic [5:0] CHANNEL_OR_COMMAND_ADDRESS, CONVERTER_CHANNEL, MONITOR_CHANNEL;
	logic [13:0] DATA_WORD_LINES, READ_DATA, CONVERTER_CODE, rd_seen;
	logic [13:0] got [0:39];
	logic [13:0] x [0:39];
	logic [13:0] m [0:39];
	logic [13:0] c [0:39];
	int fail_count = 0;
	int samples_checked = 0;
	int nwr = 0;
	integer seed = 32'h3459;
	always #50 CLOCK = ~CLOCK;
	dwdc_host host_u (.CLOCK, .WRITE_STROBE, .READ_NOT_WRITE, .SEL(sel),
		.CHANNEL_OR_COMMAND_ADDRESS, .DATA_WORD_LINES, .LOAD_OUTPUTS_STROBE_N);
	dwdc_top dut_u (.CLOCK, .SYS_RST, .WRITE_STROBE, .READ_NOT_WRITE,
		.REGISTER_SELECT_HIGH(sel[1]), .REGISTER_SELECT_LOW(sel[0]), .CHANNEL_OR_COMMAND_ADDRESS,
		.DATA_WORD_LINES, .LOAD_OUTPUTS_STROBE_N, .READ_DATA, .READ_VALID, .CONVERTER_CODE,
		.CONVERTER_CHANNEL, .CONVERTER_WRITE, .UPDATE_ALL, .INTERNAL_REFERENCE_ENABLE,
		.REFERENCE_MAGNITUDE_SELECT, .POWERED_DOWN, .MONITOR_ENABLE, .MONITOR_CHANNEL, .BUSY_N);
	// capture of the converter stream and readback
	always @(posedge CLOCK) begin
		if (CONVERTER_WRITE === 1'b1) begin
			got[CONVERTER_CHANNEL] <= CONVERTER_CODE;
			nwr <= nwr + 1;
		end
		if (READ_VALID === 1'b1) rd_seen <= READ_DATA;
	end
	// corrected code from code, gain and offset
	function automatic logic [13:0] exp_code(input logic [13:0] xv, mv, cv);
		int v;
		v = (((int'(mv) + 2) * int'(xv)) >>> 14) + int'(cv) - 8192;
		if (v < 0) v = 0;
		if (v > 16383) v = 16383;
		return 14'(v);
	endfunction
	task automatic chk(input string nm, input logic [13:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// bounded wait for a full scan to finish
	task automatic scan();
		repeat (3) @(posedge CLOCK);
		for (int k = 0; k < 300 && !(nwr == 40 && BUSY_N === 1'b1); k++) @(posedge CLOCK);
		chk("writes", 14'(nwr), 14'h0028);
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		@(negedge CLOCK);
		chk("busy", BUSY_N, 1'b1);
		chk("intref", INTERNAL_REFERENCE_ENABLE, 1'b0);
		host_u.put(1'b1, 2'h0, 6'h0c, 14'h0000);
		chk("ctrl", rd_seen, 14'h2000);
		for (int i = 0; i < 40; i++) begin
			x[i] = 14'($random(seed));
			m[i] = (i % 3 == 0) ? 14'($random(seed)) & 14'h3ffe : 14'h3ffe;
			c[i] = (i % 3 == 0) ? 14'($random(seed)) : 14'h2000;
		end
		x[0] = 14'h3fff;
		m[0] = 14'h3ffe;
		c[0] = 14'h3fff;
		x[3] = 14'h0001;
		c[3] = 14'h0000;
		for (int i = 0; i < 40; i++) begin
			host_u.put(1'b0, 2'h3, 6'(i), x[i]);
			if (i % 3 == 0) host_u.put(1'b0, 2'h2, 6'(i), c[i]);
			if (i % 3 == 0) host_u.put(1'b0, 2'h1, 6'(i), m[i] | 14'h0001);
		end
		chk("early", 14'(nwr), 14'h0000);
		host_u.load();
		scan();
		for (int i = 0; i < 40; i++) chk("code", got[i], exp_code(x[i], m[i], c[i]));
		host_u.put(1'b1, 2'h1, 6'h27, 14'h0000);
		chk("gain", rd_seen, m[39]);
		host_u.put(1'b0, 2'h0, 6'h08, 14'h0000);
		chk("pdown", POWERED_DOWN, 1'b1);
		host_u.put(1'b0, 2'h3, 6'h02, ~x[2]);
		host_u.put(1'b0, 2'h0, 6'h09, 14'h0000);
		chk("pup", POWERED_DOWN, 1'b0);
		host_u.put(1'b0, 2'h0, 6'h05, 14'h3fff);
		chk("unlisted", BUSY_N, 1'b1);
		host_u.put(1'b1, 2'h0, 6'h0c, 14'h0000);
		chk("unl_ctrl", rd_seen, 14'h2000);
		nwr = 0;
		host_u.load();
		scan();
		chk("kept", got[2], exp_code(x[2], m[2], c[2]));
		host_u.put(1'b0, 2'h0, 6'h0c, 14'h1600);
		chk("mag", REFERENCE_MAGNITUDE_SELECT, 1'b1);
		chk("mon_en", MONITOR_ENABLE, 1'b1);
		host_u.put(1'b0, 2'h0, 6'h0a, 14'h0500);
		chk("monch", MONITOR_CHANNEL, 6'h05);
		host_u.put(1'b0, 2'h0, 6'h0c, 14'h1000);
		chk("mag", REFERENCE_MAGNITUDE_SELECT, 1'b0);
		host_u.put(1'b0, 2'h0, 6'h01, 14'h2abc);
		nwr = 0;
		host_u.put(1'b0, 2'h0, 6'h02, 14'h0000);
		scan();
		for (int i = 0; i < 40; i++) chk("clear", got[i], 14'h2abc);
		nwr = 0;
		host_u.put(1'b0, 2'h0, 6'h0f, 14'h0000);
		scan();
		chk("sreset", got[7], 14'h0000);
		host_u.put(1'b1, 2'h2, 6'h00, 14'h0000);
		chk("offset", rd_seen, 14'h2000);
		finish_test();
	end
	// watchdog on a hang
	initial begin
		#4000000;
		fail_count++;
		finish_test();
	end
endmodule
